// file: hdl/ccs_sequencer.sv
// Purpose: Call supervision for a start-stop terminal on polar send and receive legs.
// Assumes: Mark is logic 1 on every leg input and output; buttons are active high levels.
// Notes: Registers are reached over classic Wishbone with 32-bit data.
//
// Behaviour
// - Proceed-to-dial pulse enters dial-ready, drives relay and lamp, sends the dial contact level.
// - A 25 ms receiving mark never declares a connection.
// - While dialing, dial contact make-break is copied to the sending leg.
// - Connection declared at the tick after 80 ms of steady receiving mark.
// - On connection clear dial-ready, operate connect relay, light lamp, start motor.
// - Connected: distributor drives sending leg and feeds own selector copy.
// - Connected: received mark and space gate the selector, sending path untouched.
// - Disconnect only after 1.3 s of steady receiving space.
// - An 80 ms mark from idle is an incoming call; connect and send mark.
// - Low paper holds the connect timer cleared; an existing call continues.
// - Stop while connected forces sending space; disconnect follows 1.3 s of space.
// - After disconnect keep sending space, blind the selector, return to idle.
// - Remote long space of 1.3 s drops the call and returns to idle.
// - Duration timers restart at once when the receiving leg changes level.
// - Idle line: sending leg space unless start is requested (then mark), and all call control outputs off.
//
// Our own choices: the register addresses and the Wishbone register port.
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = ccs_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_rx_leg,
  input wire logic i_start_btn,
  input wire logic i_stop_btn,
  input wire logic i_dial_contact,
  input wire logic i_dist_out,
  input wire logic i_low_paper,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ccs_pkg::WB_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_tx_leg,
  output logic o_selector_in,
  output logic o_dial_ready_relay,
  output logic o_dial_ready_lamp,
  output logic o_connect_relay,
  output logic o_connected_lamp,
  output logic o_motor_on
);

  import ccs_pkg::*;

  localparam int unsigned TICK_W = $clog2(P_TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_TICK_CYCLES - 1);

  generate
    if (P_TICK_CYCLES < 2) begin : g_bad_tick
      $error("ccs_sequencer: P_TICK_CYCLES must be at least 2");
    end
  endgenerate

  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic [TICK_W-1:0] tick_count;
  logic tick;
  logic connect_hit;
  logic disconnect_hit;
  ccs_state_t state;
  ccs_state_t next_state;
  logic stop_latched;
  logic [1:0] ctrl;
  logic [CONNECTED_LAMP_COUNT_W-1:0] connected_lamp_count;
  logic start_req;
  logic stop_req;
  logic wb_req;
  logic next_tx;
  logic next_selector;

  ////////////////////////////////////////////////////////////////////////////
  // Receiving leg synchroniser.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_prev <= 1'b0;
    end else begin
      rx_meta <= i_rx_leg;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe tick generator.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else if (tick_count == TICK_LAST) begin
      tick_count <= '0;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + TICK_W'(1);
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connect and disconnect timers.
  // The mark timer is held cleared under low paper and once connected.
  ccs_dur_timer #(
    .W(TIMER_W),
    .LIMIT(CONNECT_TICKS)
  ) u_mark_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_run(rx_sync && !i_low_paper && state != CCS_CONNECTED),
    .o_expired(connect_hit)
  );

  // The space timer runs only while connected so dialing space is harmless.
  ccs_dur_timer #(
    .W(TIMER_W),
    .LIMIT(DISCONNECT_TICKS)
  ) u_space_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_run(!rx_sync && state == CCS_CONNECTED),
    .o_expired(disconnect_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Button and software requests.
  assign start_req = i_start_btn || ctrl[CTRL_START_BIT];
  assign stop_req = i_stop_btn || ctrl[CTRL_STOP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Call state machine.
  always_comb begin
    next_state = state;
    unique case (state)
      CCS_IDLE: begin
        if (connect_hit) begin
          next_state = CCS_CONNECTED;
        end else if (start_req && rx_sync && !rx_prev) begin
          next_state = CCS_DIAL_READY;
        end
      end
      CCS_DIAL_READY: begin
        if (connect_hit) begin
          next_state = CCS_CONNECTED;
        end
      end
      CCS_CONNECTED: begin
        if (disconnect_hit) begin
          next_state = CCS_IDLE;
        end
      end
      default: begin
        next_state = CCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= CCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop latch: holds sending space from the stop press until disconnect.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_latched <= 1'b0;
    end else if (state == CCS_CONNECTED && next_state == CCS_IDLE) begin
      stop_latched <= 1'b0;
    end else if (state == CCS_CONNECTED && stop_req) begin
      stop_latched <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sending leg and selector input for the coming state.
  always_comb begin
    next_tx = 1'b0;
    next_selector = 1'b0;
    unique case (next_state)
      CCS_IDLE: begin
        next_tx = start_req && state != CCS_CONNECTED;
      end
      CCS_DIAL_READY: begin
        next_tx = i_dial_contact;
      end
      CCS_CONNECTED: begin
        next_tx = i_dist_out && !stop_latched && !stop_req;
        next_selector = i_dist_out && rx_sync;
      end
      default: begin
        next_tx = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_leg <= 1'b0;
      o_selector_in <= 1'b0;
    end else begin
      o_tx_leg <= next_tx;
      o_selector_in <= next_selector;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relays, lamps and motor.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dial_ready_relay <= 1'b0;
      o_dial_ready_lamp <= 1'b0;
      o_connect_relay <= 1'b0;
      o_connected_lamp <= 1'b0;
      o_motor_on <= 1'b0;
    end else begin
      o_dial_ready_relay <= next_state == CCS_DIAL_READY;
      o_dial_ready_lamp <= next_state == CCS_DIAL_READY;
      o_connect_relay <= next_state == CCS_CONNECTED;
      o_connected_lamp <= next_state == CCS_CONNECTED;
      o_motor_on <= next_state == CCS_CONNECTED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connection counter, saturating.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      connected_lamp_count <= '0;
    end else if (state != CCS_CONNECTED && next_state == CCS_CONNECTED && connected_lamp_count != '1) begin
      connected_lamp_count <= connected_lamp_count + CONNECTED_LAMP_COUNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for one cycle per request.
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (wb_req && i_wb_we && i_wb_adr == ADR_CTRL && i_wb_sel[0]) begin
      ctrl <= i_wb_dat[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (wb_req && !i_wb_we) begin
      unique case (i_wb_adr)
        ADR_CTRL: begin
          o_wb_dat <= {30'h0000_0000, ctrl};
        end
        ADR_STATUS: begin
          o_wb_dat <= {26'h000_0000, i_low_paper, stop_latched, o_tx_leg, rx_sync, state};
        end
        ADR_CONNECTED_LAMP_COUNT: begin
          o_wb_dat <= {16'h0000, connected_lamp_count};
        end
        default: begin
          o_wb_dat <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// file: hdl/ccs_pkg.sv
// Purpose: Shared constants and types for the call connect sequencer.
// Assumes: A single 25 MHz system clock.
// Notes: Times are kept in microseconds and turned into tick counts here.
package ccs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and strobe tick.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1_000;
  localparam int unsigned TICK_CYCLES = (TICK_US * (CLK_HZ / 1_000_000));

  ////////////////////////////////////////////////////////////////////////////
  // Line timing in microseconds and in strobe ticks.
  localparam int unsigned DIAL_PULSE_US = 25_000;
  localparam int unsigned CONNECT_US = 80_000;
  localparam int unsigned DISCONNECT_US = 1_300_000;
  localparam int unsigned CONNECT_TICKS = (CONNECT_US + TICK_US - 1) / TICK_US;
  localparam int unsigned DISCONNECT_TICKS = (DISCONNECT_US + TICK_US - 1) / TICK_US;
  localparam int unsigned TIMER_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on a 32-bit Wishbone bus.
  localparam int unsigned WB_ADR_W = 4;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_CONNECTED_LAMP_COUNT = 4'h8;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned CONNECTED_LAMP_COUNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Call control states.
  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_DIAL_READY = 2'b01,
    CCS_CONNECTED = 2'b10
  } ccs_state_t;

endpackage

// file: hdl/ccs_dur_timer.sv
// Purpose: Level duration timer advanced by the strobe tick.
// Assumes: The run input is already synchronous to the clock.
// Notes: Pulses o_expired at the first tick after LIMIT ticks of steady run.
module ccs_dur_timer #(
  parameter int unsigned W = 12,
  parameter int unsigned LIMIT = 80
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_run,
  output logic o_expired
);

  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);

  logic [W-1:0] count;

  generate
    if (LIMIT < 1 || LIMIT >= (2 ** W)) begin : g_bad_limit
      $error("ccs_dur_timer: LIMIT does not fit in W bits");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Count ticks while run holds; a drop of run clears at once.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= '0;
    end else if (!i_run) begin
      count <= '0;
    end else if (i_tick && count != LIMIT_W) begin
      count <= count + W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Act on the tick that follows the threshold.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_run && i_tick && (count == LIMIT_W);
    end
  end

endmodule

// file: verif/ccs_chk.sv
// Purpose: Port assertions for the call sequencer.
// Assumes: One clock, reset active high.
// Notes: Bound to the sequencer.
module ccs_chk
  import ccs_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_rx_leg,
  input wire logic i_stop_btn,
  input wire logic i_dial_contact,
  input wire logic i_dist_out,
  input wire logic i_low_paper,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic o_tx_leg,
  input wire logic o_selector_in,
  input wire logic o_dial_ready_relay,
  input wire logic o_dial_ready_lamp,
  input wire logic o_connect_relay,
  input wire logic o_connected_lamp,
  input wire logic o_motor_on
);
  localparam int LIM_C = (CONNECT_TICKS - 1) * P_TICK_CYCLES - 4;
  localparam int LIM_D = (DISCONNECT_TICKS - 1) * P_TICK_CYCLES - 4;
  logic [15:0] mk;
  logic [15:0] sp;
  logic [3:0] lp;
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths of mark, space and low paper.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mk <= 16'h0;
      sp <= 16'h0;
      lp <= 4'h0;
    end else begin
      mk <= i_rx_leg ? mk + 16'(mk != 16'hffff) : 16'h0;
      sp <= !i_rx_leg ? sp + 16'(sp != 16'hffff) : 16'h0;
      lp <= i_low_paper ? lp + 4'(lp != 4'hf) : 4'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("Ack too long.");
  a_ack_due: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("Ack missing.");
  a_dial_lamp: assert property (o_dial_ready_relay == o_dial_ready_lamp)
    else $error("Dial lamp differs.");
  a_dial_copy: assert property (o_dial_ready_relay && $past(o_dial_ready_relay) |-> o_tx_leg == $past(i_dial_contact))
    else $error("Dial not copied.");
  a_dial_excl: assert property (o_dial_ready_relay |-> !o_connect_relay)
    else $error("Dial and connect.");
  a_connected_lamp_set: assert property (o_connect_relay == o_connected_lamp && o_connect_relay == o_motor_on)
    else $error("Connect outputs differ.");
  a_connected_lamp_send: assert property (o_connect_relay && $past(o_connect_relay) && !$past(i_dist_out) &&
    !$past(i_dist_out, 2) |-> !o_tx_leg && !o_selector_in)
    else $error("Distributor not followed.");
  a_stop_space: assert property (o_connect_relay && $past(o_connect_relay) && $past(i_stop_btn) |-> !o_tx_leg)
    else $error("Stop not spacing.");
  a_blind_sel: assert property (!o_connect_relay && !o_dial_ready_relay && !$past(o_connect_relay) |->
    !o_selector_in)
    else $error("Selector not blind.");
  a_connected_lamp_time: assert property ($rose(o_connect_relay) |-> int'($past(mk, 4)) >= LIM_C)
    else $error("Connect too early.");
  a_disc_time: assert property ($fell(o_connect_relay) |-> int'($past(sp, 4)) >= LIM_D)
    else $error("Disconnect too early.");
  a_paper_hold: assert property (lp == 4'hf && !o_connect_relay |=> !o_connect_relay)
    else $error("Connect with low paper.");
endmodule
bind ccs_sequencer ccs_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) ccs_chk_inst (.i_sys_clk, .i_sys_rst, .i_rx_leg,
  .i_stop_btn, .i_dial_contact, .i_dist_out, .i_low_paper, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_tx_leg,
  .o_selector_in, .o_dial_ready_relay, .o_dial_ready_lamp, .o_connect_relay, .o_connected_lamp, .o_motor_on);

// file: verif/ccs_exchange.sv
// Purpose: Exchange model on the far side of the legs.
// Assumes: Mark is 1 on both legs.
// Notes: LAG sets how slowly it answers.
module ccs_exchange #(
  parameter int unsigned LAG = 40,
  parameter int unsigned PULSE = 100,
  parameter int unsigned STOP_LEN = 200
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_tx_leg,
  input wire logic i_call_in,
  input wire logic i_dial_done,
  input wire logic i_far_data,
  output logic o_rx_leg
);
  logic [1:0] st;
  logic [15:0] cnt;
  logic tx_q;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= 2'h0;
      cnt <= 16'h0;
      tx_q <= 1'b0;
      o_rx_leg <= 1'b0;
    end else begin
      tx_q <= i_tx_leg;
      cnt <= cnt + 16'h1;
      case (st)
        2'h0: begin
          o_rx_leg <= i_call_in;
          cnt <= 16'h0;
          if (i_tx_leg && !tx_q) begin
            st <= i_call_in ? 2'h3 : 2'h1;
          end
        end
        2'h1: begin
          o_rx_leg <= cnt >= 16'(LAG) && cnt < 16'(LAG + PULSE);
          if (cnt == 16'(LAG + PULSE)) begin
            st <= 2'h2;
          end
        end
        2'h2: begin
          o_rx_leg <= i_dial_done;
          cnt <= 16'h0;
          if (i_dial_done) begin
            st <= 2'h3;
          end
        end
        default: begin
          o_rx_leg <= i_far_data && cnt < 16'(STOP_LEN);
          cnt <= i_tx_leg ? 16'h0 : cnt + 16'h1;
          if (cnt >= 16'(STOP_LEN)) begin
            st <= 2'h0;
          end
        end
      endcase
    end
  end
endmodule

// file: verif/ccs_sequencer_tb.sv
// Purpose: Self-checking bench for the call sequencer.
// Assumes: Tick shortened to 4 clocks.
// Notes: The exchange model drives the receiving leg.
module ccs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  localparam int P = 4;
  localparam int SL = 200;
  logic i_sys_clk, i_sys_rst, i_rx_leg, i_start_btn, i_stop_btn, i_dial_contact, i_dist_out, i_low_paper;
  logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_tx_leg, o_selector_in, o_dial_ready_relay, o_dial_ready_lamp;
  logic o_connect_relay, o_connected_lamp, o_motor_on, call_in, dial_done, far_data;
  logic [3:0] i_wb_adr, i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  ccs_sequencer #(.P_TICK_CYCLES(P)) ccs_sequencer_inst (.i_sys_clk, .i_sys_rst, .i_rx_leg, .i_start_btn,
    .i_stop_btn, .i_dial_contact, .i_dist_out, .i_low_paper, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_tx_leg, .o_selector_in, .o_dial_ready_relay, .o_dial_ready_lamp,
    .o_connect_relay, .o_connected_lamp, .o_motor_on);
  ccs_exchange #(.STOP_LEN(SL)) ccs_exchange_inst (.i_sys_clk, .i_sys_rst, .i_tx_leg(o_tx_leg),
    .i_call_in(call_in), .i_dial_done(dial_done), .i_far_data(far_data), .o_rx_leg(i_rx_leg));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hf;
    do begin
      @(posedge i_sys_clk);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 20);
    check(32'(t < 20), 32'h1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic wait_on(input logic s, input logic v, input int lim);
    n = 0;
    while ((s ? o_connect_relay : o_dial_ready_relay) !== v && n < lim) begin
      @(posedge i_sys_clk);
      n++;
    end
  endtask
  task automatic win(input int lo, input int hi);
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    tk(40000);
    n_errors++;
    give_verdict();
  end
  initial begin
    i_sys_rst = 1'b1;
    {i_start_btn, i_stop_btn, i_low_paper, i_wb_cyc, i_wb_stb, i_wb_we, call_in, dial_done} = 8'h0;
    {i_dial_contact, i_dist_out, far_data} = 3'h7;
    i_wb_adr = 4'h0;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0;
    tk(8);
    i_sys_rst <= 1'b0;
    tk(2);
    check({o_tx_leg, o_selector_in, o_dial_ready_relay, o_connect_relay, o_motor_on}, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b0, ADR_CTRL, 32'h0);
    check(rd, 32'h1);
    wait_on(1'b0, 1'b1, 1000);
    tk(2);
    check({o_dial_ready_relay, o_dial_ready_lamp, o_connect_relay, o_tx_leg}, 32'hd);
    tk(500);
    check(o_connect_relay, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h0);
    i_dial_contact <= 1'b0;
    tk(3);
    check(o_tx_leg, 32'h0);
    i_dial_contact <= 1'b1;
    tk(3);
    check(o_tx_leg, 32'h1);
    dial_done <= 1'b1;
    wait_on(1'b1, 1'b1, 2000);
    win((CONNECT_TICKS - 1) * P, (CONNECT_TICKS + 2) * P + 8);
    dial_done <= 1'b0;
    tk(2);
    check({o_dial_ready_relay, o_dial_ready_lamp, o_connected_lamp, o_motor_on}, 32'h3);
    wb(1'b1, ADR_STATUS, 32'hff);
    wb(1'b0, ADR_STATUS, 32'h0);
    check(rd, 32'he);
    wb(1'b0, ADR_CONNECTED_LAMP_COUNT, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    i_dist_out <= 1'b0;
    tk(3);
    check({o_tx_leg, o_selector_in}, 32'h0);
    i_dist_out <= 1'b1;
    far_data <= 1'b0;
    tk(6);
    check({o_tx_leg, o_selector_in}, 32'h2);
    tk(1000 * P);
    far_data <= 1'b1;
    tk(3 * P);
    far_data <= 1'b0;
    wait_on(1'b1, 1'b0, 2000 * P);
    win((DISCONNECT_TICKS - 1) * P, (DISCONNECT_TICKS + 2) * P + 8);
    tk(2);
    check({o_tx_leg, o_selector_in, o_dial_ready_relay, o_connected_lamp}, 32'h0);
    far_data <= 1'b1;
    tk(SL + 20);
    call_in <= 1'b1;
    wait_on(1'b1, 1'b1, 2000);
    win((CONNECT_TICKS - 1) * P, (CONNECT_TICKS + 2) * P + 8);
    tk(3);
    call_in <= 1'b0;
    check(o_tx_leg, 32'h1);
    i_low_paper <= 1'b1;
    tk(100);
    check(o_connect_relay, 32'h1);
    i_stop_btn <= 1'b1;
    tk(3);
    check(o_tx_leg, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check(rd, 32'h36);
    wait_on(1'b1, 1'b0, 8000);
    win(SL + (DISCONNECT_TICKS - 1) * P, SL + (DISCONNECT_TICKS + 2) * P + 16);
    i_stop_btn <= 1'b0;
    tk(4);
    check(o_tx_leg, 32'h0);
    call_in <= 1'b1;
    tk(120 * P);
    check(o_connect_relay, 32'h0);
    give_verdict();
  end
endmodule
